// ==== hw/atr_pkg.sv ====
// shared constants and types for the acquisition timing and trigger router
package atr_pkg;

  // ************************************************************
  // input map and counts
  // ************************************************************
  localparam int          NUM_IN     = 13;
  localparam int          NUM_TRIG   = 8;
  localparam int          NUM_UFT    = 2;
  localparam int          SRC_W      = 4;
  localparam int          FN_W       = 16;
  localparam int          DIV_W      = 16;
  localparam logic [3:0]  SRC_TRIG0  = 4'h0;
  localparam logic [3:0]  SRC_STAR   = 4'h8;
  localparam logic [3:0]  SRC_DSTARA = 4'h9;
  localparam logic [3:0]  SRC_DSTARB = 4'ha;
  localparam logic [3:0]  SRC_UFT0   = 4'hb;
  localparam logic [3:0]  SRC_UFT1   = 4'hc;

  // ************************************************************
  // output selections for a user function terminal
  // ************************************************************
  localparam logic [3:0]  OSEL_REF   = 4'h0;
  localparam logic [3:0]  OSEL_SCLK  = 4'h1;
  localparam logic [3:0]  OSEL_START = 4'h2;
  localparam logic [3:0]  OSEL_PAUSE = 4'h3;
  localparam logic [3:0]  OSEL_STAR  = 4'h4;
  localparam logic [3:0]  OSEL_TRIG0 = 4'h5;

  // ************************************************************
  // filter timing: 100 MHz filter clock made from 125 MHz
  // ************************************************************
  localparam int          MCLK_MHZ   = 125;
  localparam int          FCLK_MHZ   = 100;
  localparam logic [7:0]  ACC_ADD    = 8'(FCLK_MHZ);
  localparam logic [7:0]  ACC_MOD    = 8'(MCLK_MHZ);
  localparam logic [FN_W-1:0] N_SHORT  = 16'h0009;
  localparam logic [FN_W-1:0] N_MEDIUM = 16'h0200;
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h0064;

  typedef enum logic [1:0] {
    ATR_FLT_OFF,
    ATR_FLT_SHORT,
    ATR_FLT_MEDIUM,
    ATR_FLT_CUSTOM
  } atr_flt_mode_t;

  typedef enum logic [1:0] {
    ATR_ROLE_NONE,
    ATR_ROLE_MASTER,
    ATR_ROLE_SLAVE
  } atr_role_t;

  typedef struct packed {
    atr_flt_mode_t         mode;
    logic [FN_W-1:0]       n;
  } atr_flt_cfg_t;

  // one routed acquisition function: source, inversion, from terminal
  typedef struct packed {
    logic                  ext;
    logic [SRC_W-1:0]      src;
    logic                  invert;
  } atr_route_t;

  typedef struct packed {
    logic                  is_out;
    logic [SRC_W-1:0]      sel;
  } atr_uft_cfg_t;

endpackage

// ==== hw/atr_router.sv ====
// timing, trigger routing and input filtering of an acquisition module
`timescale 1ns/1ps

// Functional notes
// - sample clock derives from internal 100 MHz timebase, lockable to backplane reference.
// - external sample clock selectable from trig lines, terminals, star, star A or B.
// - external clock combined with averaging, auto-zero or chopping is refused.
// - acquisition starts on selectable rising or falling edge of a digital trigger.
// - each user terminal is configured separately as timing input or output.
// - input terminals route to sample clock, start, reference, pause or timebase.
// - routed terminal inputs may be inverted.
// - pause trigger is level sensitive and holds acquisition while active.
// - output terminal driven from ref, sample clock, start, pause, star or trig line.
// - every input has a debounce filter sampled on each filter clock tick.
// - filtered output changes only after N consecutive samples at the new level.
// - filter adds at most one filter clock period of jitter.
// - filter settings off, short N=9, medium N=512, custom N, at 100 MHz.
// - each input holds its own filter setting; reset clears filtered levels and counts, not the filt_cfg settings.
// - master and slave both build sample clock from shared backplane reference.
// - an armed slave begins on the master's start trigger.
module atr_router
  import atr_pkg::*;
#(
  parameter int CNT_W = FN_W
) (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic [NUM_TRIG-1:0]    trig_in,
  output logic      [NUM_TRIG-1:0]    trig_out,
  output logic      [NUM_TRIG-1:0]    trig_oe,
  input  wire logic                   star_in,
  input  wire logic                   dstar_a_in,
  input  wire logic                   dstar_b_in,
  input  wire logic [NUM_UFT-1:0]     user_function_terminal_in,
  output logic      [NUM_UFT-1:0]     user_function_terminal_out,
  output logic      [NUM_UFT-1:0]     user_function_terminal_oe,
  input  wire logic                   ref_clk_in,
  input  wire logic                   ref_lock,
  input  wire atr_flt_cfg_t [NUM_IN-1:0] filt_cfg,
  input  wire atr_uft_cfg_t [NUM_UFT-1:0] uft_cfg,
  input  wire atr_route_t             route_sclk,
  input  wire atr_route_t             route_start,
  input  wire atr_route_t             route_ref,
  input  wire atr_route_t             route_pause,
  input  wire atr_route_t             route_tbase,
  input  wire logic                   start_falling,
  input  wire logic [DIV_W-1:0]       sample_div,
  input  wire logic                   avg_en,
  input  wire logic                   autozero_en,
  input  wire logic                   chop_en,
  input  wire atr_role_t              sync_role,
  input  wire logic [2:0]             master_trig_line,
  input  wire logic                   arm,
  input  wire logic                   sw_start,
  input  wire logic                   stop,
  output logic                        acq_sample_clock,
  output logic                        acq_start_trigger,
  output logic                        acq_reference_trigger,
  output logic                        acq_pause_trigger,
  output logic                        acq_sample_timebase,
  output logic                        acq_armed,
  output logic                        acq_running,
  output logic                        cfg_refused,
  output logic [NUM_IN-1:0]           filtered
);

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {
    ATR_IDLE,
    ATR_ARMED,
    ATR_RUN
  } atr_state_t;

  typedef struct packed {
    atr_state_t                    state;
    logic [7:0]                    acc;
    logic                          ref_q;
    logic [NUM_IN-1:0]             flt;
    logic [NUM_IN-1:0][CNT_W-1:0]  cnt;
    logic                          sclk_q;
    logic                          start_q;
    logic                          ref_src_q;
    logic                          tb_q;
    logic [DIV_W-1:0]              div;
    logic                          sclk;
    logic                          start;
    logic                          reft;
    logic                          pause;
    logic                          tbase;
    logic                          refused;
    logic [NUM_UFT-1:0]            uft_out;
    logic [NUM_UFT-1:0]            uft_oe;
    logic [NUM_TRIG-1:0]           trig_out;
    logic [NUM_TRIG-1:0]           trig_oe;
  } atr_regs_t;

  atr_regs_t r;
  atr_regs_t next_r;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic pick_src(input logic [NUM_IN-1:0] v,
                                    input logic [SRC_W-1:0]  s);
    pick_src = (s < SRC_W'(NUM_IN)) ? v[s] : 1'b0;
  endfunction

  function automatic logic [CNT_W-1:0] flt_len(input atr_flt_cfg_t c);
    case (c.mode)
      ATR_FLT_SHORT:  flt_len = CNT_W'(N_SHORT);
      ATR_FLT_MEDIUM: flt_len = CNT_W'(N_MEDIUM);
      ATR_FLT_CUSTOM: flt_len = CNT_W'(c.n);
      default:        flt_len = '0;
    endcase
  endfunction

  // routed level of one function, inversion applied; gone when not routed
  function automatic logic route_lvl(input atr_route_t    rt,
                                     input logic [NUM_IN-1:0] v);
    route_lvl = rt.ext ? (pick_src(v, rt.src) ^ rt.invert) : 1'b0;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  logic [NUM_IN-1:0] raw;
  logic [8:0]        acc_sum;
  logic              fclk_tick;
  logic              tb_tick;
  logic              ext_sclk;
  logic              bad_cfg;
  logic              lv_sclk;
  logic              lv_start;
  logic              lv_ref;
  logic              lv_tb;
  logic              start_edge;
  logic              go;
  logic [CNT_W-1:0]  nlen;

  always_comb begin
    next_r     = r;
    raw        = {user_function_terminal_in, dstar_b_in, dstar_a_in, star_in, trig_in};
    // terminals configured as outputs feed no function
    for (int u = 0; u < NUM_UFT; u++) begin
      if (uft_cfg[u].is_out) begin
        raw[int'(SRC_UFT0) + u] = 1'b0;
      end
    end
    // internal 100 MHz tick from 125 MHz: 4 of every 5 cycles
    acc_sum    = {1'b0, r.acc} + {1'b0, ACC_ADD};
    fclk_tick  = 1'b0;
    next_r.ref_q = ref_clk_in;
    if (ref_lock) begin
      fclk_tick = ref_clk_in & ~r.ref_q;
    end else if (acc_sum >= {1'b0, ACC_MOD}) begin
      fclk_tick  = 1'b1;
      next_r.acc = 8'(acc_sum - {1'b0, ACC_MOD});
    end else begin
      next_r.acc = acc_sum[7:0];
    end
    if (!ref_lock && acc_sum < {1'b0, ACC_MOD}) begin
      next_r.acc = acc_sum[7:0];
    end

    // debounce filters, one per input, each with its own setting
    for (int i = 0; i < NUM_IN; i++) begin
      nlen = flt_len(filt_cfg[i]);
      if (filt_cfg[i].mode == ATR_FLT_OFF) begin
        next_r.flt[i] = raw[i];
        next_r.cnt[i] = '0;
      end else if (fclk_tick) begin
        if (raw[i] == r.flt[i]) begin
          next_r.cnt[i] = '0;
        end else if (r.cnt[i] + CNT_W'(1) >= nlen) begin
          next_r.flt[i] = raw[i];
          next_r.cnt[i] = '0;
        end else begin
          next_r.cnt[i] = r.cnt[i] + CNT_W'(1);
        end
      end
    end

    // routed function levels from filtered inputs
    lv_sclk   = route_lvl(route_sclk, r.flt);
    lv_start  = route_lvl(route_start, r.flt);
    lv_ref    = route_lvl(route_ref, r.flt);
    lv_tb     = route_lvl(route_tbase, r.flt);
    next_r.sclk_q    = lv_sclk;
    next_r.start_q   = lv_start;
    next_r.ref_src_q = lv_ref;
    next_r.tb_q      = lv_tb;
    next_r.pause     = route_lvl(route_pause, r.flt);

    ext_sclk = route_sclk.ext;
    bad_cfg  = ext_sclk & (avg_en | autozero_en | chop_en);
    next_r.refused = bad_cfg;

    start_edge = start_falling ? (r.start_q & ~lv_start)
                               : (~r.start_q & lv_start);

    // timebase: internal tick or routed terminal edge
    tb_tick      = route_tbase.ext ? (lv_tb & ~r.tb_q) : fclk_tick;
    next_r.tbase = tb_tick;

    next_r.sclk  = 1'b0;
    next_r.start = 1'b0;
    next_r.reft  = 1'b0;
    go           = 1'b0;

    case (r.state)
      ATR_IDLE: begin
        next_r.div = '0;
        if (arm && !bad_cfg) begin
          next_r.state = ATR_ARMED;
        end
      end
      ATR_ARMED: begin
        next_r.div = '0;
        case (sync_role)
          ATR_ROLE_SLAVE:  go = start_edge;
          ATR_ROLE_MASTER: go = sw_start;
          default:         go = sw_start | start_edge;
        endcase
        if (stop || bad_cfg) begin
          next_r.state = ATR_IDLE;
        end else if (go) begin
          next_r.state = ATR_RUN;
          next_r.start = 1'b1;
        end
      end
      ATR_RUN: begin
        if (stop || bad_cfg) begin
          next_r.state = ATR_IDLE;
        end else begin
          next_r.reft = lv_ref & ~r.ref_src_q;
          if (ext_sclk) begin
            next_r.sclk = lv_sclk & ~r.sclk_q & ~r.pause;
          end else if (tb_tick) begin
            if (r.div + DIV_W'(1) >= sample_div) begin
              next_r.div  = '0;
              next_r.sclk = ~r.pause;
            end else begin
              next_r.div = r.div + DIV_W'(1);
            end
          end
        end
      end
      default: begin
        next_r.state = ATR_IDLE;
      end
    endcase

    // user terminals as outputs
    for (int u = 0; u < NUM_UFT; u++) begin
      next_r.uft_oe[u] = uft_cfg[u].is_out;
      case (uft_cfg[u].sel)
        OSEL_REF:   next_r.uft_out[u] = next_r.reft;
        OSEL_SCLK:  next_r.uft_out[u] = next_r.sclk;
        OSEL_START: next_r.uft_out[u] = next_r.start;
        OSEL_PAUSE: next_r.uft_out[u] = next_r.pause;
        OSEL_STAR:  next_r.uft_out[u] = r.flt[SRC_STAR];
        default: begin
          if (uft_cfg[u].sel >= OSEL_TRIG0 &&
              uft_cfg[u].sel < OSEL_TRIG0 + SRC_W'(NUM_TRIG)) begin
            next_r.uft_out[u] = r.flt[3'(uft_cfg[u].sel - OSEL_TRIG0)];
          end else begin
            next_r.uft_out[u] = 1'b0;
          end
        end
      endcase
      if (!uft_cfg[u].is_out) begin
        next_r.uft_out[u] = 1'b0;
      end
    end

    // master shares its start on one backplane trigger line
    next_r.trig_oe  = '0;
    next_r.trig_out = '0;
    if (sync_role == ATR_ROLE_MASTER) begin
      next_r.trig_oe[master_trig_line]  = 1'b1;
      next_r.trig_out[master_trig_line] = next_r.start;
    end

    if (reset) begin
      next_r         = '0;
      next_r.state   = ATR_IDLE;
      next_r.div     = DIV_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    r <= next_r;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign acq_sample_clock           = r.sclk;
  assign acq_start_trigger          = r.start;
  assign acq_reference_trigger      = r.reft;
  assign acq_pause_trigger          = r.pause;
  assign acq_sample_timebase        = r.tbase;
  assign acq_armed                  = (r.state == ATR_ARMED);
  assign acq_running                = (r.state == ATR_RUN);
  assign cfg_refused                = r.refused;
  assign filtered                   = r.flt;
  assign user_function_terminal_out = r.uft_out;
  assign user_function_terminal_oe  = r.uft_oe;
  assign trig_out                   = r.trig_out;
  assign trig_oe                    = r.trig_oe;

endmodule // atr_router

// ==== verification/atr_router_props.sv ====
// concurrent checks on the ports of the timing and trigger router
`timescale 1ns/1ps
module atr_router_props
  import atr_pkg::*;
#(
  parameter int CNT_W = FN_W
) (
  input wire logic                       mclk,
  input wire logic                       reset,
  input wire logic [NUM_TRIG-1:0]        trig_in,
  input wire logic [NUM_TRIG-1:0]        trig_oe,
  input wire atr_flt_cfg_t [NUM_IN-1:0]  filt_cfg,
  input wire atr_uft_cfg_t [NUM_UFT-1:0] uft_cfg,
  input wire logic [NUM_UFT-1:0]         user_function_terminal_oe,
  input wire atr_route_t                 route_sclk,
  input wire logic                       avg_en,
  input wire logic                       autozero_en,
  input wire logic                       chop_en,
  input wire atr_role_t                  sync_role,
  input wire logic [2:0]                 master_trig_line,
  input wire logic                       arm,
  input wire logic                       sw_start,
  input wire logic                       stop,
  input wire logic                       acq_sample_clock,
  input wire logic                       acq_start_trigger,
  input wire logic                       acq_pause_trigger,
  input wire logic                       acq_armed,
  input wire logic                       acq_running,
  input wire logic                       cfg_refused,
  input wire logic [NUM_IN-1:0]          filtered
);
  // ************************************************************
  // helper logic
  // ************************************************************
  logic [7:0] hi_cnt;
  logic       idle;
  assign idle = !acq_armed && !acq_running;
  // cycles that trigger line 0 has stayed high
  always_ff @(posedge mclk) begin
    if (reset || !trig_in[0]) hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hff) hi_cnt <= hi_cnt + 8'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ************************************************************
  // properties
  // ************************************************************
  sequence s_paused; acq_pause_trigger [*3]; endsequence
  sequence s_go; acq_armed && sw_start && !stop && sync_role != ATR_ROLE_SLAVE; endsequence
  property p_refused;
    !$past(reset) |-> cfg_refused == $past(route_sclk.ext && (avg_en || autozero_en || chop_en));
  endproperty
  property p_arm; idle && arm && !cfg_refused && !stop ##1 !cfg_refused |-> acq_armed; endproperty
  property p_no_arm; idle && arm ##1 cfg_refused |-> !acq_armed; endproperty
  property p_start; s_go ##1 !cfg_refused |-> acq_running && acq_start_trigger; endproperty
  property p_pulse; acq_start_trigger |=> !acq_start_trigger; endproperty
  property p_uft_oe;
    !$past(reset) |-> user_function_terminal_oe == {$past(uft_cfg[1].is_out), $past(uft_cfg[0].is_out)};
  endproperty
  property p_master_oe;
    !$past(reset) && $past(sync_role) == ATR_ROLE_MASTER |-> trig_oe[$past(master_trig_line)];
  endproperty
  property p_filt_off;
    !$past(reset) && $past(filt_cfg[0].mode) == ATR_FLT_OFF |-> filtered[0] == $past(trig_in[0]);
  endproperty
  property p_pause; s_paused |-> !acq_sample_clock; endproperty
  property p_short; $rose(filtered[0]) && filt_cfg[0].mode == ATR_FLT_SHORT |-> hi_cnt >= 8'h09; endproperty
  a_refused: assert property (p_refused) else $error("refusal flag wrong");
  a_arm: assert property (p_arm) else $error("arm not taken");
  a_no_arm: assert property (p_no_arm) else $error("armed while refused");
  a_start: assert property (p_start) else $error("start not taken");
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  a_uft_oe: assert property (p_uft_oe) else $error("terminal direction wrong");
  a_master_oe: assert property (p_master_oe) else $error("master line not driven");
  a_filt_off: assert property (p_filt_off) else $error("disabled filter delays");
  a_pause: assert property (p_pause) else $error("sample clock while paused");
  a_short: assert property (p_short) else $error("short filter passed early");
endmodule // atr_router_props

bind atr_router atr_router_props #(.CNT_W(CNT_W)) u_props (.*);

// ==== verification/atr_bp_model.sv ====
// backplane timing controller model: reference clock and trigger lines
`timescale 1ns/1ps
module atr_bp_model
  import atr_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic [NUM_TRIG-1:0] trig_out,
  input  wire logic [NUM_TRIG-1:0] trig_oe,
  output logic      [NUM_TRIG-1:0] trig_in,
  output logic                     ref_clk_in
);
  logic [NUM_TRIG-1:0] lvl = '0;
  initial ref_clk_in = 1'b0;
  // same reference copy to every slot, one rising edge per two cycles
  always @(negedge mclk) ref_clk_in <= ~ref_clk_in;
  // a module driving a line wins over the controller
  assign trig_in = (trig_oe & trig_out) | (~trig_oe & lvl);
  // hold a line level for a number of reference edges
  task automatic set_line(input int idx, input logic v, input int ticks);
    lvl[idx] = v;
    repeat (2 * ticks) @(negedge mclk);
  endtask
endmodule // atr_bp_model

// ==== verification/tb_top.sv ====
// self-checking bench for the timing and trigger router
`timescale 1ns/1ps
module tb_top;
  import atr_pkg::*;
  logic                       mclk = 1'b0;
  logic                       reset = 1'b1;
  logic [NUM_TRIG-1:0]        trig_in, trig_out, trig_oe;
  logic [NUM_UFT-1:0]         uft_in = 2'b10;
  logic [NUM_UFT-1:0]         uft_out, uft_oe;
  logic                       ref_clk_in, sclk, start_p, reftrig, pause, tbase;
  logic                       armed, running, refused;
  logic [NUM_IN-1:0]          filtered;
  atr_flt_cfg_t [NUM_IN-1:0]  filt_cfg = '0;
  atr_uft_cfg_t [NUM_UFT-1:0] uft_cfg = {5'h00, 1'b1, OSEL_START};
  atr_route_t                 route_sclk = '0;
  atr_route_t                 route_start = '{1'b1, 4'h3, 1'b0};
  atr_route_t                 route_pause = '{1'b1, SRC_UFT1, 1'b1};
  atr_role_t                  role = ATR_ROLE_SLAVE;
  logic                       fe = 1'b0, avg = 1'b0, az = 1'b0, chop = 1'b0;
  logic                       arm = 1'b0, sw_start = 1'b0, stop = 1'b0;
  logic                       lock = 1'b1;
  int                         errors = 0, check_count = 0;
  int                         n_sclk = 0, n_ref = 0, n_tb = 0;
  int                         b_sclk = 0, b_ref = 0, b_tb = 0;
  int                         nv [3] = '{9, 512, 5};
  always #4 mclk = ~mclk;
  // running counts of output pulses, sampled where they are settled
  always @(negedge mclk) begin
    n_sclk <= n_sclk + int'(sclk);
    n_ref  <= n_ref + int'(reftrig);
    n_tb   <= n_tb + int'(tbase);
  end
  atr_bp_model bp (.mclk(mclk), .trig_out(trig_out), .trig_oe(trig_oe), .trig_in(trig_in),
                   .ref_clk_in(ref_clk_in));
  atr_router uut (.mclk(mclk), .reset(reset), .trig_in(trig_in), .trig_out(trig_out),
    .trig_oe(trig_oe), .star_in(1'b0), .dstar_a_in(1'b0), .dstar_b_in(1'b0),
    .user_function_terminal_in(uft_in), .user_function_terminal_out(uft_out),
    .user_function_terminal_oe(uft_oe), .ref_clk_in(ref_clk_in), .ref_lock(lock),
    .filt_cfg(filt_cfg), .uft_cfg(uft_cfg), .route_sclk(route_sclk), .route_start(route_start),
    .route_ref(route_sclk), .route_pause(route_pause), .route_tbase(route_sclk),
    .start_falling(fe), .sample_div(16'h0002), .avg_en(avg), .autozero_en(az), .chop_en(chop),
    .sync_role(role), .master_trig_line(3'h5), .arm(arm), .sw_start(sw_start), .stop(stop),
    .acq_sample_clock(sclk), .acq_start_trigger(start_p), .acq_reference_trigger(reftrig),
    .acq_pause_trigger(pause), .acq_sample_timebase(tbase), .acq_armed(armed),
    .acq_running(running), .cfg_refused(refused), .filtered(filtered));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input logic a, input logic e);
    check_count++;
    if (a !== e) begin
      errors++;
      $display("BAD %0t value mismatch", $time);
    end
  endtask
  task automatic mark();
    b_sclk = n_sclk;
    b_ref  = n_ref;
    b_tb   = n_tb;
  endtask
  task automatic pulse_arm();
    arm = 1'b1;
    tick(1);
    arm = 1'b0;
    tick(1);
  endtask
  task automatic give_verdict();
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
  initial begin
    tick(3);
    reset = 1'b0;
    tick(1);
    chk(armed, 1'b0);
    chk(filtered[4], 1'b0);
    chk(uft_oe[0], 1'b1);
    uft_in[1] = 1'b0;
    tick(4);
    chk(pause, 1'b1);
    uft_in[1] = 1'b1;
    tick(4);
    chk(pause, 1'b0);
    route_sclk.ext = 1'b1;
    for (int k = 0; k < 3; k++) begin
      {avg, az, chop} = 3'b100 >> k;
      tick(2);
      chk(refused, 1'b1);
      pulse_arm();
      chk(armed, 1'b0);
    end
    {avg, az, chop} = 3'b000;
    tick(2);
    chk(refused, 1'b0);
    route_sclk.ext = 1'b0;
    for (int i = 0; i < 3; i++) begin
      filt_cfg[i] = '{atr_flt_mode_t'(i + 1), 16'(nv[i])};
      bp.set_line(i, 1'b1, nv[i] - 1);
      bp.set_line(i, 1'b0, 3);
      chk(filtered[i], 1'b0);
      bp.set_line(i, 1'b1, nv[i] + 3);
      chk(filtered[i], 1'b1);
      bp.set_line(i, 1'b0, nv[i] - 1);
      chk(filtered[i], 1'b1);
      bp.set_line(i, 1'b0, 4);
      chk(filtered[i], 1'b0);
    end
    bp.set_line(4, 1'b1, 1);
    chk(filtered[4], 1'b1);
    for (int k = 0; k < 2; k++) begin
      fe = k[0];
      bp.set_line(3, fe, 2);
      pulse_arm();
      chk(armed, 1'b1);
      sw_start = 1'b1;
      tick(1);
      sw_start = 1'b0;
      tick(1);
      chk(running, 1'b0);
      bp.set_line(3, !fe, 3);
      chk(running, 1'b1);
      stop = 1'b1;
      tick(1);
      stop = 1'b0;
      tick(1);
      chk(running, 1'b0);
    end
    role = ATR_ROLE_MASTER;
    tick(2);
    chk(trig_oe[5], 1'b1);
    pulse_arm();
    sw_start = 1'b1;
    tick(1);
    chk(start_p, 1'b1);
    chk(trig_out[5], 1'b1);
    chk(uft_out[0], 1'b1);
    sw_start = 1'b0;
    tick(4);
    // locked timebase: tick every 2 cycles, sample clock every 2 ticks
    mark();
    tick(16);
    chk(n_sclk - b_sclk == 4, 1'b1);
    chk(n_tb - b_tb == 8, 1'b1);
    // free-running timebase: 4 ticks in every 5 cycles
    lock = 1'b0;
    tick(5);
    mark();
    tick(20);
    chk(n_sclk - b_sclk == 8, 1'b1);
    chk(n_tb - b_tb == 16, 1'b1);
    // pause level holds off sample clocks while running
    uft_in[1] = 1'b0;
    tick(3);
    mark();
    tick(20);
    chk(n_sclk - b_sclk == 0, 1'b1);
    chk(running, 1'b1);
    uft_in[1] = 1'b1;
    tick(3);
    // external sample clock, reference and timebase from trigger line 6
    route_sclk = '{1'b1, 4'h6, 1'b0};
    tick(2);
    mark();
    bp.set_line(6, 1'b1, 4);
    chk(n_sclk - b_sclk == 1, 1'b1);
    chk(n_ref - b_ref == 1, 1'b1);
    chk(n_tb - b_tb == 1, 1'b1);
    give_verdict();
  end
endmodule // tb_top
